/* lss_pkg.sv */
/*
  Shared constants and types of the locator slot scheduler: register map,
  register layouts, slot timing, burst schedule and message field values.
  Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package lss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TWO_SEC_S = 2;
  localparam int unsigned CYC_2S = TWO_SEC_S * CLK_HZ;
  localparam int ACC_W = 27;
  localparam int unsigned SLOTS_2S = 75;
  localparam int unsigned BITS_SLOT = 256;
  localparam int unsigned FIRST_TX_S = 60;
  localparam int unsigned FIRST_MAX_SLOTS = FIRST_TX_S * SLOTS_2S / TWO_SEC_S;
  localparam int SLOT_W = 12;
  localparam logic [SLOT_W-1:0] SLOTS_FRAME = 12'h8ca;
  localparam logic [SLOT_W-1:0] BURST_GAP = 12'h04b;
  localparam logic [SLOT_W-1:0] BURST_SPAN = 12'h20d;
  localparam logic [SLOT_W-1:0] INC_MIN = 12'h7e9;
  localparam logic [8:0] INC_SPAN = 9'h1c2;
  localparam logic [8:0] INC_FOLD = 9'h100;
  localparam logic [2:0] BURST_LAST = 3'h7;
  localparam logic [2:0] SET_LAST = 3'h7;
  localparam logic [2:0] TEXT_BURST_B = 3'h4;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ID = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SLOT = 8'h0c;

  typedef struct packed {
    logic [29:0] rsvd;
    logic test;
    logic act;
  } lss_ctrl_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [2:0] burst;
    logic [2:0] idx;
    logic have_fix;
    logic lock;
    logic busy;
    logic [1:0] state;
  } lss_stat_t;

  typedef struct packed {
    logic [3:0] rsvd1;
    logic [SLOT_W-1:0] first;
    logic [3:0] rsvd0;
    logic [SLOT_W-1:0] slot;
  } lss_slot_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_FIX, ST_RUN, ST_DONE} lss_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // message fields
  localparam int PAY_W = 168;
  localparam logic [5:0] MSG_POS_ID = 6'h01;
  localparam logic [5:0] MSG_TXT_ID = 6'h0e;
  localparam logic [1:0] REPEAT_IND = 2'h0;
  localparam logic [3:0] NAV_ACTIVE = 4'he;
  localparam logic [3:0] NAV_TEST = 4'hf;
  localparam logic [7:0] ROT_DEF = 8'h80;
  localparam logic [8:0] HDG_DEF = 9'h1ff;
  localparam logic [5:0] TS_LOST = 6'h3e;
  localparam logic [5:0] TS_NONE = 6'h3c;
  localparam logic [1:0] SYNC_UTC = 2'h0;
  localparam logic [1:0] SYNC_NONE = 2'h3;
  localparam logic [2:0] TO_START = 3'h7;
  localparam logic [13:0] SUB_STATIONS = 14'h0000;
  localparam logic [27:0] LON_NONE = 28'h6791ac0;
  localparam logic [26:0] LAT_NONE = 27'h3412140;
  localparam logic [9:0] SOG_NONE = 10'h3ff;
  localparam logic [11:0] COG_NONE = 12'he10;
  localparam logic [7:0] LEN_POS = 8'ha8;
  localparam logic [7:0] LEN_TXT_ACT = 8'h64;
  localparam logic [7:0] LEN_TXT_TEST = 8'h58;
  localparam logic [7:0] TRAIN_BITS = 8'h18;
  localparam logic [7:0] FLAG_BITS = 8'h08;
  localparam logic [7:0] FLAG = 8'h7e;
  localparam logic [59:0] TXT_ACTIVE = {6'h0d, 6'h0f, 6'h02, 6'h20, 6'h01,
                                        6'h03, 6'h14, 6'h09, 6'h16, 6'h05};
  localparam logic [59:0] TXT_TEST = {6'h0d, 6'h0f, 6'h02, 6'h20, 6'h14,
                                      6'h05, 6'h13, 6'h14, 6'h00, 6'h00};

endpackage

/* lss_tx_if.sv */
/*
  Carrier between the scheduler and the slot serializer: frame start,
  payload, payload length, bit-rate enable and busy.
  Assumes one clock domain; start and bit_tick are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
interface lss_tx_if;
  import lss_pkg::*;
  logic start;
  logic [PAY_W-1:0] payload;
  logic [7:0] len;
  logic bit_tick;
  logic busy;
  modport ctl (output start, output payload, output len, output bit_tick, input busy);
  modport ser (input start, input payload, input len, input bit_tick, output busy);
endinterface
`default_nettype wire

/* lss_frac_tick.sv */
/*
  Fractional rate divider: adds step every clock modulo a period and pulses
  on each wrap. A sync pulse reloads the phase.
  Assumes step below modulo; tick comes one cycle after the wrapping edge.
*/
`timescale 1ns/10ps
`default_nettype none
module lss_frac_tick #(
  parameter int ACC_W = 27
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ACC_W-1:0] step_i,
  input wire logic [ACC_W-1:0] modulo_i,
  input wire logic sync_i,
  input wire logic [ACC_W-1:0] load_i,
  output logic tick_o
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W:0] sum;
  logic wrap;

  assign sum = {1'h0, acc_r} + {1'h0, step_i};
  assign wrap = (sum >= {1'h0, modulo_i});

  // no cumulative error: the remainder is kept, so a wrap lands within one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= '0;
      tick_o <= 1'h0;
    end else if (sync_i) begin
      acc_r <= load_i;
      tick_o <= (load_i == '0);
    end else begin
      acc_r <= wrap ? ACC_W'(sum - {1'h0, modulo_i}) : sum[ACC_W-1:0];
      tick_o <= wrap;
    end
  end
endmodule
`default_nettype wire

/* lss_tx_serial.sv */
/*
  Slot serializer: on start sends training bits, opening flag, payload MSB
  first and closing flag, one bit per bit enable, then idles.
  Assumes the next start comes only after the frame is over.
*/
`timescale 1ns/10ps
`default_nettype none
module lss_tx_serial (
  input wire logic clk_i,
  input wire logic rst_i,
  lss_tx_if.ser tx,
  output logic tx_en_o,
  output logic tx_bit_o
);
  import lss_pkg::*;
  logic [7:0] cnt_r;
  logic [7:0] len_r;
  logic [PAY_W-1:0] sh_r;
  logic [7:0] nx;
  logic [7:0] cl;

  assign nx = cnt_r + 8'h01;
  assign cl = nx - TRAIN_BITS - FLAG_BITS - len_r;
  assign tx.busy = tx_en_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
      len_r <= 8'h00;
      sh_r <= '0;
      tx_en_o <= 1'h0;
      tx_bit_o <= 1'h0;
    end else if (tx.start) begin
      cnt_r <= 8'h00;
      len_r <= tx.len;
      sh_r <= tx.payload;
      tx_en_o <= 1'h1;
      tx_bit_o <= 1'h0;
    end else if (tx_en_o && tx.bit_tick) begin
      cnt_r <= nx;
      if (nx < TRAIN_BITS) begin
        tx_bit_o <= nx[0];
      end else if (nx < TRAIN_BITS + FLAG_BITS) begin
        tx_bit_o <= FLAG[~nx[2:0]];
      end else if (nx < TRAIN_BITS + FLAG_BITS + len_r) begin
        tx_bit_o <= sh_r[PAY_W-1];
        sh_r <= {sh_r[PAY_W-2:0], 1'h0};
      end else if (cl < FLAG_BITS) begin
        tx_bit_o <= FLAG[~cl[2:0]];
      end else begin
        tx_en_o <= 1'h0;
        tx_bit_o <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* lss_top.sv */
/*
  Locator slot scheduler: UTC-disciplined slot timebase, burst scheduling of
  position reports and safety text, message composition, Wishbone registers.
  Assumes GNSS inputs synchronous to clk_i and a single-cycle pps pulse or
  level whose rising edge marks the second given on utc_sec_i.
*/
// Functional notes
// - active mode: first message sent within 60 s of activation
// - first message with valid GNSS position sent within 5 minutes
// - 75 slot starts per two seconds; odd second offset by half slot
// - slot start within 312 us of ideal UTC boundary while fixed
// - report: id 1, repeat 0, status 14, default turn/heading, UTC second
// - speed, course, position from GNSS; accuracy follows integrity check
// - text message: id 14, repeat 0, source identity, MOB ACTIVE
// - one burst per minute, 8 messages spanning 14 s
// - burst messages 75 slots apart on alternating channels
// - slot set kept 8 minutes, then advanced by random 2025..2475 slots
// - GNSS present: direct UTC sync, sync state 0 in reports
// - time-out 7 on first burst after set change, minus 1 per frame
// - sub-message chosen from time-out value (test mode sends SUB_STATIONS, not the offset, at time-out 0)
// - text every 4 minutes, alternating channels, replacing a report
// - text never replaces a report with time-out 0 (test mode sends its text in place of the first report, time-out 0)
// - GNSS lost: same schedule, sync 3, held position, stamp 62
// - test mode: wait fix, one burst of 8, status 15, MOB TEST, stop
// - test mode without GNSS sends nothing
// - each frame opens with 24 alternating training bits starting 0
// - slot lasts 256 bits; modulator idle after message end
`timescale 1ns/10ps
`default_nettype none
module lss_top #(
  parameter int unsigned CYC_2S_P = lss_pkg::CYC_2S
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lss_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pps_i,
  input wire logic gnss_valid_i,
  input wire logic gnss_raim_i,
  input wire logic gnss_acc_i,
  input wire logic [27:0] gnss_lon_i,
  input wire logic [26:0] gnss_lat_i,
  input wire logic [9:0] gnss_sog_i,
  input wire logic [11:0] gnss_cog_i,
  input wire logic [5:0] utc_sec_i,
  input wire logic [4:0] utc_hour_i,
  input wire logic [5:0] utc_min_i,
  output logic tx_en_o,
  output logic tx_bit_o,
  output logic tx_chan_o,
  output logic slot_start_marker_o
);
  import lss_pkg::*;

  localparam logic [ACC_W-1:0] MOD_2S = ACC_W'(CYC_2S_P);
  localparam logic [ACC_W-1:0] HALF_2S = MOD_2S >> 1;
  localparam logic [ACC_W-1:0] SLOT_STEP = ACC_W'(SLOTS_2S);
  localparam logic [ACC_W-1:0] BIT_STEP = ACC_W'(SLOTS_2S * BITS_SLOT);

  function automatic logic [31:0] lss_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [13:0] lss_sub(input logic [2:0] to,
                                          input logic [SLOT_W-1:0] slot,
                                          input logic [4:0] hr,
                                          input logic [5:0] mn,
                                          input logic [SLOT_W-1:0] ofs);
    logic [13:0] res;
    res = SUB_STATIONS;
    unique case (to)
      3'h3, 3'h5, 3'h7: res = SUB_STATIONS;
      3'h2, 3'h4, 3'h6: res = {2'h0, slot};
      3'h1: res = {hr, 1'h0, mn, 2'h0};
      3'h0: res = {2'h0, ofs};
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // timebase

  logic pps_q;
  logic pps_rise;
  logic sync_go;
  logic slot_tick;
  logic [SLOT_W-1:0] slot_r;
  lss_tx_if tx_if ();

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pps_q <= 1'h0;
    end else begin
      pps_q <= pps_i;
    end
  end

  assign pps_rise = pps_i & ~pps_q;
  assign sync_go = pps_rise & gnss_valid_i;

  // odd seconds start half a slot late
  lss_frac_tick #(.ACC_W(ACC_W)) u_slot_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(SLOT_STEP),
    .modulo_i(MOD_2S),
    .sync_i(sync_go),
    .load_i(utc_sec_i[0] ? HALF_2S : '0),
    .tick_o(slot_tick)
  );

  lss_frac_tick #(.ACC_W(ACC_W)) u_bit_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(BIT_STEP),
    .modulo_i(MOD_2S),
    .sync_i(sync_go),
    .load_i('0),
    .tick_o(tx_if.bit_tick)
  );

  // frame slot number; realigned at the top of each UTC minute when fixed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_r <= '0;
    end else if (sync_go && utc_sec_i == 6'h00) begin
      // the tick right after the pulse opens slot 0, so park on the last slot
      slot_r <= SLOTS_FRAME - 12'h001;
    end else if (slot_tick) begin
      slot_r <= (slot_r == SLOTS_FRAME - 12'h001) ? '0 : slot_r + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  lss_ctrl_t ctrl_r;
  logic [29:0] id_r;
  logic ack_r;
  logic wb_hit;
  logic [31:0] ctrl_wr;
  logic [31:0] id_wr;
  lss_stat_t stat;
  lss_slot_t slot_rd;
  lss_state_t state_r;
  logic test_r;
  logic have_fix_r;
  logic [2:0] idx_r;
  logic [2:0] burst_r;
  logic [SLOT_W-1:0] first_r;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_ack_o = ack_r;
  assign ctrl_wr = lss_merge(ctrl_r, wb_dat_i, wb_sel_i);
  assign id_wr = lss_merge({2'h0, id_r}, wb_dat_i, wb_sel_i);

  always_comb begin
    stat = '0;
    stat.state = state_r;
    stat.busy = tx_if.busy;
    stat.lock = gnss_valid_i;
    stat.have_fix = have_fix_r;
    stat.idx = idx_r;
    stat.burst = burst_r;
    slot_rd = '0;
    slot_rd.slot = slot_r;
    slot_rd.first = first_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'h0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= ctrl_r;
          REG_ID: wb_dat_o <= {2'h0, id_r};
          REG_STAT: wb_dat_o <= stat;
          REG_SLOT: wb_dat_o <= slot_rd;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
      id_r <= '0;
    end else if (wb_hit && wb_we_i) begin
      if (wb_adr_i == REG_CTRL) begin
        ctrl_r.act <= ctrl_wr[0];
        ctrl_r.test <= ctrl_wr[1];
      end
      if (wb_adr_i == REG_ID) begin
        id_r <= id_wr[29:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // GNSS hold

  logic [27:0] lon_r;
  logic [26:0] lat_r;
  logic [9:0] sog_r;
  logic [11:0] cog_r;

  // last valid values survive a loss
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lon_r <= LON_NONE;
      lat_r <= LAT_NONE;
      sog_r <= SOG_NONE;
      cog_r <= COG_NONE;
      have_fix_r <= 1'h0;
    end else if (gnss_valid_i) begin
      lon_r <= gnss_lon_i;
      lat_r <= gnss_lat_i;
      sog_r <= gnss_sog_i;
      cog_r <= gnss_cog_i;
      have_fix_r <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // schedule

  logic [15:0] lfsr_r;
  logic [8:0] rnd;
  logic [SLOT_W-1:0] wait_r;
  logic [SLOT_W-1:0] inc_r;
  logic chan_r;
  logic fire;
  logic [2:0] to;
  logic txt_sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_r <= LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // folding keeps the draw within the span without a divider
  assign rnd = (lfsr_r[8:0] > INC_SPAN) ? lfsr_r[8:0] - INC_FOLD : lfsr_r[8:0];
  assign fire = (state_r == ST_RUN) && slot_tick && (wait_r == '0);

  // time-out counts down burst by burst
  assign to = test_r ? 3'h0 : TO_START - burst_r;

  // text on first report of burst 0, second of burst 4
  assign txt_sel = (test_r ? (idx_r == 3'h0)
                    : ((burst_r == 3'h0 && idx_r == 3'h0) ||
                       (burst_r == TEXT_BURST_B && idx_r == 3'h1))) && (to != 3'h0 || test_r);

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_r.act) begin
      state_r <= ST_IDLE;
      test_r <= 1'h0;
      wait_r <= '0;
      idx_r <= 3'h0;
      burst_r <= 3'h0;
      chan_r <= 1'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // first slot a few seconds out, far below the limit
          test_r <= ctrl_r.test;
          wait_r <= {4'h0, lfsr_r[7:0]};
          idx_r <= 3'h0;
          burst_r <= 3'h0;
          chan_r <= 1'h0;
          state_r <= ctrl_r.test ? ST_WAIT_FIX : ST_RUN;
        end
        ST_WAIT_FIX: begin
          // nothing goes out until a fix
          if (gnss_valid_i) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (slot_tick) begin
            if (wait_r != '0) begin
              wait_r <= wait_r - 12'h001;
            end else begin
              chan_r <= ~chan_r;
              idx_r <= idx_r + 3'h1;
              if (idx_r != BURST_LAST) begin
                wait_r <= BURST_GAP - 12'h001;
              end else if (test_r) begin
                state_r <= ST_DONE;
              end else begin
                burst_r <= burst_r + 3'h1;
                wait_r <= (burst_r == SET_LAST) ? inc_r - BURST_SPAN - 12'h001
                                                : SLOTS_FRAME - BURST_SPAN - 12'h001;
              end
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
      endcase
    end
  end

  // draw increment at the first message of the last burst of a set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inc_r <= INC_MIN;
      first_r <= '0;
    end else if (fire && idx_r == 3'h0) begin
      first_r <= slot_r;
      if (burst_r == SET_LAST) begin
        inc_r <= INC_MIN + {3'h0, rnd};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compose

  logic [PAY_W-1:0] pos_msg;
  logic [PAY_W-1:0] txt_msg;
  logic [5:0] ts;
  logic [1:0] sync_st;
  logic [13:0] sub;

  // sync 3 without; stamp 62 after a loss, 60 before any fix
  assign sync_st = gnss_valid_i ? SYNC_UTC : SYNC_NONE;
  assign ts = gnss_valid_i ? utc_sec_i : (have_fix_r ? TS_LOST : TS_NONE);
  assign sub = test_r ? SUB_STATIONS : lss_sub(to, slot_r, utc_hour_i, utc_min_i, inc_r);

  assign pos_msg = {MSG_POS_ID, REPEAT_IND, id_r, test_r ? NAV_TEST : NAV_ACTIVE,
                    ROT_DEF, sog_r, gnss_valid_i & gnss_raim_i & gnss_acc_i,
                    lon_r, lat_r, cog_r, HDG_DEF, ts, 2'h0, 3'h0,
                    gnss_valid_i & gnss_raim_i, sync_st, to, sub};
  assign txt_msg = {MSG_TXT_ID, REPEAT_IND, id_r, 2'h0,
                    test_r ? TXT_TEST : TXT_ACTIVE, 68'h0};

  // start one clock after the boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_if.start <= 1'h0;
      tx_if.payload <= '0;
      tx_if.len <= 8'h00;
      tx_chan_o <= 1'h0;
      slot_start_marker_o <= 1'h0;
    end else begin
      tx_if.start <= fire;
      slot_start_marker_o <= fire;
      if (fire) begin
        tx_chan_o <= chan_r;
        tx_if.payload <= txt_sel ? txt_msg : pos_msg;
        tx_if.len <= txt_sel ? (test_r ? LEN_TXT_TEST : LEN_TXT_ACT) : LEN_POS;
      end
    end
  end

  lss_tx_serial u_ser (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tx(tx_if.ser),
    .tx_en_o(tx_en_o),
    .tx_bit_o(tx_bit_o)
  );

endmodule
`default_nettype wire

/* lss_top_chk.sv */
/*
  Port checks of the locator slot scheduler: bus answer and frame shape.
  Assumes binding to lss_top, one clock, synchronous active high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module lss_top_chk #(
  parameter int unsigned CYC_2S_P = 40000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_en_o,
  input wire logic tx_bit_o,
  input wire logic tx_chan_o,
  input wire logic slot_start_marker_o
);
  localparam int SLOT_CLK = CYC_2S_P / 75;
  localparam int FRAME_MAX = 241 * SLOT_CLK / 256;
  localparam int MIN_GAP = 75 * SLOT_CLK - 2;
  int en_cnt;
  int gap;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_en_o) en_cnt <= 0;
    else en_cnt <= en_cnt + 1;
  end
  // starts large so the first frame after reset has no predecessor
  always_ff @(posedge clk_i) begin
    if (rst_i) gap <= 1 << 30;
    else if (slot_start_marker_o) gap <= 0;
    else if (gap < (1 << 30)) gap <= gap + 1;
  end
  ////////////////////////////////////////
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_marker_starts: assert property (
    slot_start_marker_o |=> tx_en_o && !$past(tx_en_o) && !tx_bit_o)
    else $error("marker not at frame start with 0 bit");
  a_en_marked: assert property ($rose(tx_en_o) |-> $past(slot_start_marker_o))
    else $error("frame without marker");
  a_idle_low: assert property (!tx_en_o |-> !tx_bit_o)
    else $error("bit active outside frame");
  a_chan_hold: assert property (tx_en_o && $past(tx_en_o) |-> $stable(tx_chan_o))
    else $error("channel changed in frame");
  a_frame_fits: assert property (tx_en_o |-> en_cnt < FRAME_MAX)
    else $error("frame overruns slot");
  a_slot_spacing: assert property (slot_start_marker_o |-> gap >= MIN_GAP)
    else $error("frames closer than 75 slots");
  c_chan1: cover property (slot_start_marker_o && tx_chan_o);
  c_frame_end: cover property ($fell(tx_en_o));
  c_bus: cover property (wb_ack_o);
endmodule
bind lss_top lss_top_chk #(.CYC_2S_P(CYC_2S_P)) chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .tx_en_o(tx_en_o),
  .tx_bit_o(tx_bit_o),
  .tx_chan_o(tx_chan_o),
  .slot_start_marker_o(slot_start_marker_o)
);
`default_nettype wire

/* lss_rx_model.sv */
/*
  Listening station: captures each frame bit by bit with its channel.
  Assumes frames on tx enable, BIT_CLK clocks a bit, first bit one short.
*/
`timescale 1ns/10ps
`default_nettype none
module lss_rx_model #(
  parameter int BIT_CLK = 2
) (
  input wire logic clk_i,
  input wire logic tx_en_i,
  input wire logic tx_bit_i,
  input wire logic tx_chan_i,
  output logic [0:255] bits_o,
  output var int nbits_o,
  output var int frames_o,
  output var int start_o,
  output logic chan_o
);
  int cnt = 0;
  int cyc = 0;
  logic en_q = 1'b0;
  initial frames_o = 0;
  // sampling at each multiple of BIT_CLK keeps the short first bit and the rest aligned
  always @(posedge clk_i) begin
    cyc++;
    if (tx_en_i) begin
      if (!en_q) begin
        cnt = 0;
        bits_o = '0;
        chan_o = tx_chan_i;
        start_o = cyc;
      end
      if (cnt % BIT_CLK == 0 && cnt / BIT_CLK < 256) bits_o[cnt / BIT_CLK] = tx_bit_i;
      cnt++;
    end else if (en_q) begin
      nbits_o = (cnt + BIT_CLK - 1) / BIT_CLK;
      frames_o++;
    end
    en_q = tx_en_i;
  end
endmodule
`default_nettype wire

/* lss_top_tb.sv */
/*
  Bench of the locator slot scheduler: registers, test mode without fix,
  first three messages of an active burst, two with fix then one after loss. Assumes lss_rx_model on tx side.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module lss_top_tb;
  import lss_pkg::*;
  localparam int unsigned C2S = 19200;
  localparam int SLOT = C2S / 75;
  localparam int SEC = C2S / 2;
  localparam logic [31:0] ID_VAL = 32'h2aaa5555;
  localparam logic [27:0] LON_V = 28'h1234567;
  localparam logic [26:0] LAT_V = 27'h0abcdef;
  localparam logic [9:0] SOG_V = 10'h0c8;
  localparam logic [11:0] COG_V = 12'h384;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_we = 1'b0, ack, en, txb, chan, mark, rx_chan;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wd = 32'h0, wb_rd, rd;
  logic pps = 1'b0, valid = 1'b0;
  logic [5:0] sec = 6'h00, sec_snap;
  logic [27:0] lon = LON_V;
  logic [26:0] lat = LAT_V;
  logic [9:0] sog = SOG_V;
  logic [11:0] cog = COG_V;
  logic [0:255] fb;
  int nbits, frames, t0, t_prev, pc = 0, errors = 0, n_compared = 0;
  always #25 clk_i = ~clk_i;
  // utc second changes one clock ahead of its pulse
  always @(posedge clk_i) begin
    pc <= (pc == SEC - 1) ? 0 : pc + 1;
    pps <= (pc == SEC - 1);
    if (pc == SEC - 2) sec <= (sec == 6'h3b) ? 6'h00 : sec + 6'h01;
  end
  lss_top #(.CYC_2S_P(C2S)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(ack), .pps_i(pps),
    .gnss_valid_i(valid), .gnss_raim_i(1'b1), .gnss_acc_i(1'b1), .gnss_lon_i(lon),
    .gnss_lat_i(lat), .gnss_sog_i(sog), .gnss_cog_i(cog), .utc_sec_i(sec),
    .utc_hour_i(5'h0a), .utc_min_i(6'h1e), .tx_en_o(en), .tx_bit_o(txb),
    .tx_chan_o(chan), .slot_start_marker_o(mark));
  lss_rx_model #(.BIT_CLK(SLOT / 256)) rx (.clk_i(clk_i), .tx_en_i(en), .tx_bit_i(txb),
    .tx_chan_i(chan), .bits_o(fb), .nbits_o(nbits), .frames_o(frames), .start_o(t0),
    .chan_o(rx_chan));
  ////////////////////////////////////////
  task automatic summarize();
    $display("errors %0d n_compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wd <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      errors++;
      summarize();
    end
    rd = wb_rd;
    wb_cyc <= 1'b0;
  endtask
  task automatic wait_frame(input int n);
    int i;
    i = 0;
    while (frames < n && i < 400 * SLOT) begin
      @(negedge clk_i);
      if (mark === 1'b1) sec_snap = sec;
      i++;
    end
    if (frames < n) begin
      errors++;
      summarize();
    end
  endtask
  function automatic logic [31:0] fld(input int p, input int w);
    logic [31:0] v;
    v = '0;
    for (int k = 0; k < w; k++) v = {v[30:0], fb[32 + p + k]};
    return v;
  endfunction
  ////////////////////////////////////////
  task automatic chk_frame(input int len);
    `CHK(nbits, len + 40)
    for (int k = 0; k < 24; k++) `CHK(fb[k], k[0])
    `CHK(fld(-8, 8), 32'(FLAG))
  endtask
  task automatic chk_report(input logic [1:0] sy, input logic [5:0] ts, input logic a);
    chk_frame(168);
    `CHK(fld(0, 6), 32'(MSG_POS_ID))
    `CHK(fld(6, 2), 32'(REPEAT_IND))
    `CHK(fld(38, 4), 32'(NAV_ACTIVE))
    `CHK(fld(42, 8), 32'(ROT_DEF))
    `CHK(fld(50, 10), 32'(SOG_V))
    `CHK(fld(60, 1), 32'(a))
    `CHK(fld(61, 28), 32'(LON_V))
    `CHK(fld(89, 27), 32'(LAT_V))
    `CHK(fld(116, 12), 32'(COG_V))
    `CHK(fld(128, 9), 32'(HDG_DEF))
    `CHK(fld(137, 6), 32'(ts))
    `CHK(fld(148, 1), 32'(a))
    `CHK(fld(149, 2), 32'(sy))
    `CHK(fld(151, 3), 32'(TO_START))
  endtask
  task automatic t_regs();
    wb(1'b1, REG_ID, ID_VAL);
    wb(1'b0, REG_ID, 32'h0);
    `CHK(rd, ID_VAL & 32'h3fffffff)
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_test_nofix();
    wb(1'b1, REG_CTRL, 32'h3);
    repeat (8 * SLOT) @(posedge clk_i);
    wb(1'b0, REG_STAT, 32'h0);
    `CHK(rd[1:0], 2'(ST_WAIT_FIX))
    `CHK(frames, 0)
    wb(1'b1, REG_CTRL, 32'h0);
  endtask
  task automatic t_active();
    valid <= 1'b1;
    repeat (SEC + 8) @(posedge clk_i);
    wb(1'b1, REG_CTRL, 32'h1);
    wait_frame(1);
    chk_frame(100);
    `CHK(fld(0, 6), 32'(MSG_TXT_ID))
    `CHK(fld(6, 2), 32'(REPEAT_IND))
    `CHK(fld(8, 30), ID_VAL & 32'h3fffffff)
    `CHK(fld(40, 30), 32'(TXT_ACTIVE[59:30]))
    `CHK(fld(70, 30), 32'(TXT_ACTIVE[29:0]))
    `CHK(rx_chan, 1'b0)
    t_prev = t0;
    wait_frame(2);
    chk_report(SYNC_UTC, sec_snap, 1'b1);
    `CHK(t0 - t_prev, 75 * SLOT)
    `CHK(rx_chan, 1'b1)
    `CHK(fld(154, 14), 32'(SUB_STATIONS))
    t_prev = t0;
    @(posedge clk_i);
    valid <= 1'b0;
    lon <= 28'h0;
    lat <= 27'h0;
    sog <= 10'h0;
    cog <= 12'h0;
    wait_frame(3);
    chk_report(SYNC_NONE, TS_LOST, 1'b0);
    `CHK(t0 - t_prev, 75 * SLOT)
    `CHK(rx_chan, 1'b0)
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_test_nofix();
    t_active();
    summarize();
  end
endmodule
`default_nettype wire
